// ==== src/dtp_defs.vh ====
`ifndef DTP_DEFS_VH
`define DTP_DEFS_VH

// ****************************************************
// Register addresses (9-bit configuration space)
// ****************************************************
`define DTP_ADDR_TEST_CFG    9'h090
`define DTP_ADDR_LOW_DP01    9'h092
`define DTP_ADDR_LOW_DP23    9'h093
`define DTP_ADDR_LOW_DP45    9'h094
`define DTP_ADDR_LOW_DP67    9'h095
`define DTP_ADDR_HIGH_ALL    9'h096
`define DTP_ADDR_SPARE_A     9'h09a
`define DTP_ADDR_SPARE_B     9'h09b

// ****************************************************
// Reset values
// ****************************************************
`define DTP_RST_TEST_CFG     16'h0000
`define DTP_RST_LOW_DP01     16'h0100
`define DTP_RST_LOW_DP23     16'h0302
`define DTP_RST_LOW_DP45     16'h0504
`define DTP_RST_LOW_DP67     16'h0706
`define DTP_RST_HIGH_ALL     16'h0000
`define DTP_RST_SPARE        16'h0000

// ****************************************************
// Field positions and widths
// ****************************************************
`define DTP_CFG_INSERT_BIT   0
`define DTP_CFG_INC_BIT      1
`define DTP_CFG_WIDTH        5
`define DTP_LOW_WIDTH        8
`define DTP_HIGH_WIDTH       2
`define DTP_VAL_WIDTH        10
`define DTP_DP_COUNT         8

// ****************************************************
// Serial frame: 9 address bits, 1 write bit, 16 data bits
// ****************************************************
`define DTP_SPI_ADDR_BITS    9
`define DTP_SPI_HDR_BITS     10
`define DTP_SPI_FRAME_BITS   26
`define DTP_SPI_DATA_BITS    16

`endif

// ==== src/dtp_regs.v ====
// Notes on behaviour
// - Low bytes paired, even datapath in low byte
// - High bits packed, joined above low byte
// - Low bytes reset to datapath index
// - Programmed values drive outputs only when enabled
// - Config bit 0 replaces image data
// - Config bit 1 selects incrementing pattern
// - Datapath 0 low byte resets to zero
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defs.vh"

module dtp_regs #(
  parameter DP_COUNT = `DTP_DP_COUNT,
  parameter VAL_W    = `DTP_VAL_WIDTH
) (
  input  wire                      clk_sys,
  input  wire                      resetn,
  input  wire                      spi_sck,
  input  wire                      spi_ss_n,
  input  wire                      spi_mosi,
  output reg                       spi_miso_q,
  input  wire                      img_valid,
  input  wire [DP_COUNT*VAL_W-1:0] img_data,
  output reg                       out_valid_q,
  output reg  [DP_COUNT*VAL_W-1:0] out_data_q
);

  // ****************************************************
  // Local constants
  // ****************************************************
  // Counts stay 32 bits wide and are cut to the counter width on purpose
  localparam [31:0]               HDR_N          = `DTP_SPI_HDR_BITS;
  localparam [31:0]               FRAME_N        = `DTP_SPI_FRAME_BITS;
  localparam [31:0]               HDR_LAST_N     = `DTP_SPI_HDR_BITS - 1;
  localparam [31:0]               FRAME_LAST_N   = `DTP_SPI_FRAME_BITS - 1;
  localparam [4:0]                CNT_HDR        = HDR_N[4:0];
  localparam [4:0]                CNT_FRAME      = FRAME_N[4:0];
  localparam [4:0]                CNT_HDR_LAST   = HDR_LAST_N[4:0];
  localparam [4:0]                CNT_FRAME_LAST = FRAME_LAST_N[4:0];
  localparam [15:0]               RST_CFG_WORD   = `DTP_RST_TEST_CFG;
  localparam [`DTP_CFG_WIDTH-1:0] RST_CFG        = RST_CFG_WORD[`DTP_CFG_WIDTH-1:0];
  localparam [VAL_W-1:0]          RAMP_STEP      = {{(VAL_W-1){1'b0}}, 1'b1};

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  reg  [1:0] sck_s_q;
  reg  [1:0] ss_s_q;
  reg  [1:0] mosi_s_q;
  reg        sck_prev_q;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      sck_s_q    <= 2'h0;
      ss_s_q     <= 2'h3;
      mosi_s_q   <= 2'h0;
      sck_prev_q <= 1'b0;
    end else begin
      sck_s_q    <= {sck_s_q[0], spi_sck};
      ss_s_q     <= {ss_s_q[0], spi_ss_n};
      mosi_s_q   <= {mosi_s_q[0], spi_mosi};
      sck_prev_q <= sck_s_q[1];
    end
  end

  wire sel  = ~ss_s_q[1];
  wire rise = sel & sck_s_q[1] & ~sck_prev_q;
  wire fall = sel & ~sck_s_q[1] & sck_prev_q;

  // ****************************************************
  // Register storage
  // ****************************************************
  reg [`DTP_CFG_WIDTH-1:0] cfg_q;
  reg [15:0]               low_q [0:3];
  reg [15:0]               high_q;
  reg [15:0]               spare_a_q;
  reg [15:0]               spare_b_q;

  // Read decode, shared by the frame logic
  function [15:0] rd_word;
    input [8:0] a;
    begin
      case (a)
        `DTP_ADDR_TEST_CFG: rd_word = {{(16-`DTP_CFG_WIDTH){1'b0}}, cfg_q};
        `DTP_ADDR_LOW_DP01: rd_word = low_q[0];
        `DTP_ADDR_LOW_DP23: rd_word = low_q[1];
        `DTP_ADDR_LOW_DP45: rd_word = low_q[2];
        `DTP_ADDR_LOW_DP67: rd_word = low_q[3];
        `DTP_ADDR_HIGH_ALL: rd_word = high_q;
        `DTP_ADDR_SPARE_A:  rd_word = spare_a_q;
        `DTP_ADDR_SPARE_B:  rd_word = spare_b_q;
        default:            rd_word = 16'h0000;
      endcase
    end
  endfunction

  // ****************************************************
  // Serial frame engine
  // ****************************************************
  reg [4:0]  bit_cnt_q;
  reg [25:0] sh_in_q;
  reg [15:0] sh_out_q;

  wire [25:0] sh_next = {sh_in_q[24:0], mosi_s_q[1]};
  wire        wr_go   = rise && (bit_cnt_q == CNT_FRAME_LAST) && sh_in_q[15];
  wire [8:0]  wr_addr = sh_next[25:17];
  wire [15:0] wr_data = sh_next[15:0];

  always @(posedge clk_sys) begin
    if (!resetn) begin
      bit_cnt_q  <= 5'h00;
      sh_in_q    <= 26'h0000000;
      sh_out_q   <= 16'h0000;
      spi_miso_q <= 1'b0;
    end else if (!sel) begin
      // Deselect aborts a partial frame, so a glitch never commits a write
      bit_cnt_q  <= 5'h00;
      sh_out_q   <= 16'h0000;
      spi_miso_q <= 1'b0;
    end else begin
      if (rise) begin
        sh_in_q <= sh_next;
        if (bit_cnt_q != CNT_FRAME) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
        if (bit_cnt_q == CNT_HDR_LAST) begin
          sh_out_q <= rd_word(sh_next[9:1]);
        end
      end
      if (fall && bit_cnt_q >= CNT_HDR && bit_cnt_q < CNT_FRAME) begin
        spi_miso_q <= sh_out_q[15];
        sh_out_q   <= {sh_out_q[14:0], 1'b0};
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      cfg_q     <= RST_CFG;
      low_q[0]  <= `DTP_RST_LOW_DP01;
      low_q[1]  <= `DTP_RST_LOW_DP23;
      low_q[2]  <= `DTP_RST_LOW_DP45;
      low_q[3]  <= `DTP_RST_LOW_DP67;
      high_q    <= `DTP_RST_HIGH_ALL;
      spare_a_q <= `DTP_RST_SPARE;
      spare_b_q <= `DTP_RST_SPARE;
    end else if (wr_go) begin
      case (wr_addr)
        `DTP_ADDR_TEST_CFG: cfg_q     <= wr_data[`DTP_CFG_WIDTH-1:0];
        `DTP_ADDR_LOW_DP01: low_q[0]  <= wr_data;
        `DTP_ADDR_LOW_DP23: low_q[1]  <= wr_data;
        `DTP_ADDR_LOW_DP45: low_q[2]  <= wr_data;
        `DTP_ADDR_LOW_DP67: low_q[3]  <= wr_data;
        `DTP_ADDR_HIGH_ALL: high_q    <= wr_data;
        `DTP_ADDR_SPARE_A:  spare_a_q <= wr_data;
        `DTP_ADDR_SPARE_B:  spare_b_q <= wr_data;
        default:            cfg_q     <= cfg_q;
      endcase
    end
  end

  // ****************************************************
  // Pattern insertion
  // ****************************************************
  wire insert_en = cfg_q[`DTP_CFG_INSERT_BIT];
  wire inc_en    = cfg_q[`DTP_CFG_INC_BIT];

  // Shared ramp offset; wraps at 10 bits, restarts whenever incrementing is off
  reg [VAL_W-1:0] ramp_q;
  reg [VAL_W-1:0] ramp_d;

  // Ramp only moves on valid beats, so blanking leaves the pattern still
  always @* begin
    ramp_d = ramp_q;
    if (!(insert_en && inc_en)) begin
      ramp_d = {VAL_W{1'b0}};
    end else if (img_valid) begin
      ramp_d = ramp_q + RAMP_STEP;
    end
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      ramp_q <= {VAL_W{1'b0}};
    end else begin
      ramp_q <= ramp_d;
    end
  end

  wire [DP_COUNT*VAL_W-1:0] pat_data;

  genvar g;
  generate
    for (g = 0; g < DP_COUNT; g = g + 1) begin : g_dp
      wire [7:0]       lo   = low_q[g/2][(g%2)*8 +: 8];
      wire [1:0]       hi   = high_q[2*g +: 2];
      wire [VAL_W-1:0] base = {hi, lo};
      wire [VAL_W-1:0] ramped = base + ramp_q;
      assign pat_data[g*VAL_W +: VAL_W] = inc_en ? ramped : base;
    end
  endgenerate

  reg [DP_COUNT*VAL_W-1:0] out_data_d;

  // Stored values stay invisible unless insertion is switched on
  always @* begin
    out_data_d = insert_en ? pat_data : img_data;
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      out_valid_q <= 1'b0;
      out_data_q  <= {DP_COUNT*VAL_W{1'b0}};
    end else begin
      out_valid_q <= img_valid;
      out_data_q  <= out_data_d;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/dtp_regs_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************
// Port checks
// ************
module dtp_regs_chk (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        spi_ss_n,
  input wire logic        spi_miso_q,
  input wire logic        img_valid,
  input wire logic [79:0] img_data,
  input wire logic        out_valid_q,
  input wire logic [79:0] out_data_q
);
  logic fr_q;
  default clocking @(posedge clk_sys); endclocking
  // Insertion needs a frame first, so until then data must pass
  always @(posedge clk_sys) fr_q <= resetn && (fr_q || !spi_ss_n);
  a_rst_data_zero: assert property (!resetn |=> out_data_q == '0) else $error("data not cleared");
  a_rst_valid_zero: assert property (!resetn |=> !out_valid_q) else $error("valid not cleared");
  a_rst_miso_zero: assert property (!resetn |=> !spi_miso_q) else $error("miso not cleared");
  a_valid_rise: assert property (disable iff (!resetn) resetn && img_valid |=> out_valid_q)
    else $error("valid lost");
  a_valid_fall: assert property (disable iff (!resetn) resetn && !img_valid |=> !out_valid_q)
    else $error("valid stuck");
  a_pass_img: assert property (disable iff (!resetn) resetn && !fr_q |=> out_data_q == $past(img_data))
    else $error("image altered");
  a_miso_idle: assert property (disable iff (!resetn) spi_ss_n [*6] |-> !spi_miso_q)
    else $error("miso busy idle");
  a_idle_hold: assert property (disable iff (!resetn) spi_ss_n [*8] ##0
    (resetn && $past(resetn) && !img_valid && !$past(img_valid) && $stable(img_data)) |=> $stable(out_data_q))
    else $error("data moved");
endmodule
bind dtp_regs dtp_regs_chk dtp_regs_chk_inst (.clk_sys, .resetn, .spi_ss_n, .spi_miso_q, .img_valid, .img_data,
  .out_valid_q, .out_data_q);
`default_nettype wire

// ==== testbench/dtp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************
// Serial host
// ************
module dtp_host_model (
  input  wire logic clk_sys,
  output var  logic spi_sck,
  output var  logic spi_ss_n,
  output var  logic spi_mosi,
  input  wire logic spi_miso_q
);
  initial begin
    spi_sck = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Six-cycle half period stays clear of the four-cycle minimum
  task automatic xfer(input logic [8:0] a, input logic w, input logic [15:0] d, output logic [15:0] r);
    logic [25:0] fr;
    fr = {a, w, d};
    r = 16'h0000;
    spi_ss_n = 1'b0;
    for (int i = 25; i >= 0; i--) begin
      spi_mosi = fr[i];
      tick(6);
      spi_sck = 1'b1;
      if (i < 16) r[i] = spi_miso_q;
      tick(6);
      spi_sck = 1'b0;
    end
    tick(6);
    spi_ss_n = 1'b1;
    // Released line shows no stale bit
    spi_mosi = ~spi_mosi;
    tick(8);
  endtask
endmodule
`default_nettype wire

// ==== testbench/dtp_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defs.vh"
// ************
// Tests
// ************
module dtp_regs_test;
  logic        clk_sys, resetn, img_valid;
  logic [79:0] img_data, exp_v;
  logic [15:0] rd;
  logic [15:0] hv = 16'hb4e1;
  logic [15:0] wv [4] = '{16'h5ac3, 16'hff00, 16'h00ff, 16'h9e17};
  wire         spi_sck, spi_ss_n, spi_mosi, spi_miso_q, out_valid_q;
  wire  [79:0] out_data_q;
  int          failures = 0;
  int          num_checks = 0;
  dtp_regs dtp_regs_inst (.clk_sys, .resetn, .spi_sck, .spi_ss_n, .spi_mosi, .spi_miso_q, .img_valid,
    .img_data, .out_valid_q, .out_data_q);
  dtp_host_model dtp_host_model_inst (.clk_sys, .spi_sck, .spi_ss_n, .spi_mosi, .spi_miso_q);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic xfer(input logic [8:0] a, input logic w, input logic [15:0] d);
    dtp_host_model_inst.xfer(a, w, d, rd);
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [15:0] e);
    xfer(a, 1'b0, 16'h0000);
    check("register", {64'h0, rd}, {64'h0, e});
  endtask
  task automatic test_done;
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    img_valid = 1'b1;
    img_data = 80'h1234_5678_9abc_def0_1357;
    dtp_host_model_inst.tick(8);
    resetn = 1'b1;
    dtp_host_model_inst.tick(2);
    check("image", out_data_q, img_data);
    rd_chk(`DTP_ADDR_TEST_CFG, 16'h0000);
    rd_chk(`DTP_ADDR_LOW_DP01, 16'h0100);
    for (int k = 1; k < 4; k++) rd_chk(9'h092 + 9'(k), {8'(2 * k + 1), 8'(2 * k)});
    rd_chk(`DTP_ADDR_HIGH_ALL, 16'h0000);
    for (int k = 0; k < 4; k++) xfer(9'h092 + 9'(k), 1'b1, wv[k]);
    xfer(`DTP_ADDR_HIGH_ALL, 1'b1, hv);
    xfer(9'h091, 1'b1, 16'hffff);
    for (int k = 0; k < 4; k++) rd_chk(9'h092 + 9'(k), wv[k]);
    rd_chk(`DTP_ADDR_HIGH_ALL, hv);
    rd_chk(9'h091, 16'h0000);
    rd_chk(`DTP_ADDR_SPARE_B, 16'h0000);
    xfer(`DTP_ADDR_SPARE_A, 1'b1, 16'h1e2d);
    rd_chk(`DTP_ADDR_SPARE_A, 16'h1e2d);
    xfer(`DTP_ADDR_TEST_CFG, 1'b1, 16'h0001);
    for (int n = 0; n < 8; n++) exp_v[10 * n +: 10] = {hv[2 * n +: 2], wv[n / 2][8 * (n % 2) +: 8]};
    check("pattern", out_data_q, exp_v);
    xfer(`DTP_ADDR_TEST_CFG, 1'b1, 16'h0003);
    exp_v = out_data_q;
    dtp_host_model_inst.tick(1);
    check("ramp", {70'h0, out_data_q[9:0]}, {70'h0, exp_v[9:0] + 10'h001});
    xfer(`DTP_ADDR_TEST_CFG, 1'b1, 16'h0000);
    check("image", out_data_q, img_data);
    img_valid = 1'b0;
    dtp_host_model_inst.tick(3);
    check("valid", {79'h0, out_valid_q}, 80'h0);
    test_done;
  end
endmodule
`default_nettype wire
